// *** m2pc_pkg.sv ***
// What this block does
// - Three mode-2 configuration bytes at 2Bh, 2Ch, 2Dh, host read/write.
// - ON-pin action bit clear: valid ON falling edge in mode 2 returns device to mode 0.
// - ON-pin action bit set (reset value): ON falling edge changes no mode.
// - System buck offset bit adds 0 V when clear, 1.2 V when set.
// - System buck code: 1.500 V plus 25 mV per step, clamped at 2.100 V.
// - Always-on regulator code: 1.700 V plus 25 mV per step, clamped at 1.900 V.
// - Bits 3..0 at 2Ch enable four rails in mode 2, all reset to one.
// - Watchdog field: 00 off, 01 16 s, 10 32 s, 11 64 s; reset 00.
// - System linear regulator offset bit adds 0 V clear, 1.2 V set.
//
// Shared constants of the mode-2 configuration register bank.
// Assumes one 200 MHz clock and an I2C target port on plain pins.
package m2pc_pkg;
	localparam logic [7:0] REG_ON_SYSBUCK_ADDR = 8'h2B;
	localparam logic [7:0] REG_RAIL_EN_ADDR = 8'h2C;
	localparam logic [7:0] REG_WATCHDOG_ADDR = 8'h2D;

	localparam logic [7:0] REG_ON_SYSBUCK_RESET = 8'h4C;
	localparam logic [7:0] REG_RAIL_EN_RESET = 8'h4F;
	localparam logic [7:0] REG_WATCHDOG_RESET = 8'h0C;

	// Field positions.
	localparam int RESERVED_BIT_POS = 7;
	localparam int ON_CFG_POS = 6;
	localparam int SYS_BUCK_OFFSET_POS = 5;
	localparam int SYS_BUCK_CODE_MSB = 4;
	localparam int AON_CODE_MSB = 7;
	localparam int AON_CODE_LSB = 4;
	localparam int CORE_BUCK_EN_POS = 3;
	localparam int SYS_BUCK_EN_POS = 2;
	localparam int AON_EN_POS = 1;
	localparam int SYS_LIN_EN_POS = 0;
	localparam int WATCHDOG_MSB = 7;
	localparam int WATCHDOG_LSB = 6;
	localparam int SYS_LIN_OFFSET_POS = 5;

	// Voltages in millivolts.
	localparam logic [11:0] STEP_MV = 12'h019;
	localparam logic [11:0] OFFSET_MV = 12'h4B0;
	localparam logic [11:0] SYS_BUCK_BASE_MV = 12'h5DC;
	localparam logic [7:0] SYS_BUCK_MAX_CODE = 8'h18;
	localparam logic [11:0] AON_BASE_MV = 12'h6A4;
	localparam logic [7:0] AON_MAX_CODE = 8'h08;

	// Watchdog periods in seconds.
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_16S = 2'h1;
	localparam logic [1:0] WD_32S = 2'h2;
	localparam logic [7:0] WD_16S_SEC = 8'h10;
	localparam logic [7:0] WD_32S_SEC = 8'h20;
	localparam logic [7:0] WD_64S_SEC = 8'h40;

	localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		M2PC_IDLE,
		M2PC_ADDR,
		M2PC_ADDR_ACK,
		M2PC_PTR,
		M2PC_PTR_ACK,
		M2PC_WDATA,
		M2PC_WACK,
		M2PC_RDATA,
		M2PC_RACK
	} m2pc_state_t;
endpackage

// *** m2pc_code_to_mv.sv ***
// Converts a regulator output code into millivolts with clamping and offset.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module m2pc_code_to_mv
	import m2pc_pkg::*;
#(
	parameter int CODE_W = 5,
	parameter logic [11:0] BASE_MV = SYS_BUCK_BASE_MV,
	parameter logic [7:0] MAX_CODE = SYS_BUCK_MAX_CODE
) (
	input wire logic [CODE_W-1:0] code, // Output voltage code.
	input wire logic offset_en, // Adds the fixed offset when high.
	output logic [11:0] mv // Resulting voltage in millivolts.
);
	// The clamp compares in a byte, so wider codes cannot be served.
	if (CODE_W < 1 || CODE_W > 8) begin
		$error("m2pc_code_to_mv: CODE_W must lie in 1..8");
	end

	logic [7:0] code_wide;
	logic [7:0] code_clamped;
	logic [19:0] step_product;

	always_comb begin
		code_wide = 8'(code);
		// Codes above the top step all give the top voltage.
		code_clamped = (code_wide > MAX_CODE) ? MAX_CODE : code_wide;
		step_product = 20'(code_clamped) * 20'(STEP_MV);
		mv = 12'(BASE_MV + step_product[11:0] + (offset_en ? OFFSET_MV : 12'h000));
	end
endmodule

// *** m2pc_mode2_regs.sv ***
// Mode-2 configuration register bank with its own I2C target port.
// Assumes SCL and SDA arrive asynchronously from pins, and that the mode
// control logic beside it supplies mode2_active and a debounced ON-pin edge pulse.
`timescale 1ns/1ps
module m2pc_mode2_regs
	import m2pc_pkg::*;
#(
	parameter logic [6:0] I2C_TARGET_ADDR = 7'h5A // Arbitrary target address.
) (
	input wire logic clk, // 200 MHz clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic scl_in, // I2C clock pin level.
	input wire logic sda_in, // I2C data pin level.
	output logic sda_out, // I2C data drive value, always low.
	output logic sda_oe_n, // Low while pulling SDA low.
	input wire logic mode2_active, // Mode setting 2 is the active mode.
	input wire logic on_fall_valid, // One-cycle pulse on a valid ON-pin falling edge.
	output logic return_to_mode0, // One-cycle request to switch back to mode 0.
	output logic core_buck_enable_m2, // Core buck enable.
	output logic system_buck_enable_m2, // System buck enable.
	output logic always_on_reg_enable_m2, // Always-on regulator enable.
	output logic system_linear_reg_enable_m2, // System linear regulator enable.
	output logic [4:0] system_buck_code_m2, // System buck output code.
	output logic system_buck_offset_m2, // System buck offset select.
	output logic [11:0] system_buck_mv, // System buck target voltage in mV.
	output logic [3:0] always_on_reg_code_m2, // Always-on regulator code.
	output logic [11:0] always_on_reg_mv, // Always-on regulator target in mV.
	output logic [1:0] watchdog_period_m2, // Watchdog period select.
	output logic [7:0] watchdog_period_s, // Watchdog period in seconds, zero when off.
	output logic system_linear_reg_offset_m2 // System linear regulator offset select.
);
	logic [7:0] on_sysbuck_reg;
	logic [7:0] rail_en_reg;
	logic [7:0] watchdog_reg;

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	m2pc_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic master_nack_reg;
	logic wr_en;
	logic drive_low_next;

	logic [11:0] sys_buck_mv_next;
	logic [11:0] aon_mv_next;

	function automatic logic [7:0] reg_read(input logic [7:0] addr,
			input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
		logic [7:0] val;
		val = 8'h00;
		unique case (addr)
			REG_ON_SYSBUCK_ADDR: val = r0;
			REG_RAIL_EN_ADDR: val = r1;
			REG_WATCHDOG_ADDR: val = r2;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	function automatic logic [7:0] wd_seconds(input logic [1:0] sel);
		logic [7:0] sec;
		sec = WD_64S_SEC;
		unique case (sel)
			WD_OFF: sec = 8'h00;
			WD_16S: sec = WD_16S_SEC;
			WD_32S: sec = WD_32S_SEC;
			default: sec = WD_64S_SEC;
		endcase
		return sec;
	endfunction

	// Pin synchronisers; edges are judged only on the second stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl_rise = scl_sync_reg[1] && !scl_prev_reg;
	assign scl_fall = !scl_sync_reg[1] && scl_prev_reg;
	assign start_cond = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
	assign stop_cond = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
	assign wr_en = scl_fall && (state_reg == M2PC_WDATA) && (bit_cnt_reg == I2C_BITS_PER_BYTE);

	// Byte-level target sequencer; the register pointer survives a repeated start.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= M2PC_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			master_nack_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= M2PC_IDLE;
		end else if (start_cond) begin
			state_reg <= M2PC_ADDR;
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise) begin
			unique case (state_reg)
				M2PC_ADDR, M2PC_PTR, M2PC_WDATA, M2PC_RDATA: begin
					shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
					bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
				end
				M2PC_RACK: master_nack_reg <= sda_sync_reg[1];
				default: ;
			endcase
		end else if (scl_fall) begin
			unique case (state_reg)
				M2PC_IDLE: ;
				M2PC_ADDR: begin
					if (bit_cnt_reg == I2C_BITS_PER_BYTE) begin
						rw_reg <= shift_reg[0];
						state_reg <= (shift_reg[7:1] == I2C_TARGET_ADDR) ? M2PC_ADDR_ACK : M2PC_IDLE;
					end
				end
				M2PC_ADDR_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (rw_reg) begin
						tx_reg <= reg_read(ptr_reg, on_sysbuck_reg, rail_en_reg, watchdog_reg);
						state_reg <= M2PC_RDATA;
					end else begin
						state_reg <= M2PC_PTR;
					end
				end
				M2PC_PTR: begin
					if (bit_cnt_reg == I2C_BITS_PER_BYTE) begin
						ptr_reg <= shift_reg;
						state_reg <= M2PC_PTR_ACK;
					end
				end
				M2PC_WDATA: begin
					if (bit_cnt_reg == I2C_BITS_PER_BYTE) begin
						state_reg <= M2PC_WACK;
					end
				end
				M2PC_PTR_ACK, M2PC_WACK: begin
					if (state_reg == M2PC_WACK) begin
						ptr_reg <= 8'(ptr_reg + 8'h01);
					end
					bit_cnt_reg <= 4'h0;
					state_reg <= M2PC_WDATA;
				end
				M2PC_RDATA: begin
					if (bit_cnt_reg == I2C_BITS_PER_BYTE) begin
						state_reg <= M2PC_RACK;
					end else begin
						tx_reg <= {tx_reg[6:0], 1'b1};
					end
				end
				M2PC_RACK: begin
					if (master_nack_reg) begin
						state_reg <= M2PC_IDLE;
					end else begin
						ptr_reg <= 8'(ptr_reg + 8'h01);
						tx_reg <= reg_read(8'(ptr_reg + 8'h01), on_sysbuck_reg, rail_en_reg, watchdog_reg);
						bit_cnt_reg <= 4'h0;
						state_reg <= M2PC_RDATA;
					end
				end
			endcase
		end
	end

	// SDA drive follows the state one clock late, well inside the data hold time.
	always_comb begin
		unique case (state_reg)
			M2PC_ADDR_ACK, M2PC_PTR_ACK, M2PC_WACK: drive_low_next = 1'b1;
			// The last data bit is held until SCL falls; releasing it early would look like a stop.
			M2PC_RDATA: drive_low_next = !tx_reg[7];
			default: drive_low_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_oe_n <= 1'b1;
		end else begin
			sda_oe_n <= !drive_low_next;
		end
	end

	assign sda_out = 1'b0;

	// Writes land in any mode; unmapped addresses are acknowledged and dropped.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			on_sysbuck_reg <= REG_ON_SYSBUCK_RESET;
			rail_en_reg <= REG_RAIL_EN_RESET;
			watchdog_reg <= REG_WATCHDOG_RESET;
		end else if (wr_en) begin
			unique case (ptr_reg)
				REG_ON_SYSBUCK_ADDR: on_sysbuck_reg <= shift_reg;
				REG_RAIL_EN_ADDR: rail_en_reg <= shift_reg;
				REG_WATCHDOG_ADDR: watchdog_reg <= shift_reg;
				default: ;
			endcase
		end
	end

	// An ON-pin edge only matters in mode 2, so mode 0 never sees a redundant switch.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			return_to_mode0 <= 1'b0;
		end else begin
			return_to_mode0 <= on_fall_valid && mode2_active && !on_sysbuck_reg[ON_CFG_POS];
		end
	end

	m2pc_code_to_mv #(
		.CODE_W(5),
		.BASE_MV(SYS_BUCK_BASE_MV),
		.MAX_CODE(SYS_BUCK_MAX_CODE)
	) u_sys_buck_mv (
		.code(on_sysbuck_reg[SYS_BUCK_CODE_MSB:0]),
		.offset_en(on_sysbuck_reg[SYS_BUCK_OFFSET_POS]),
		.mv(sys_buck_mv_next)
	);

	m2pc_code_to_mv #(
		.CODE_W(4),
		.BASE_MV(AON_BASE_MV),
		.MAX_CODE(AON_MAX_CODE)
	) u_aon_mv (
		.code(rail_en_reg[AON_CODE_MSB:AON_CODE_LSB]),
		.offset_en(1'b0),
		.mv(aon_mv_next)
	);

	// Outside mode 2 every configuration output rests at zero so another mode's bank can own the rails.
	always_ff @(posedge clk) begin
		if (!rst_n || !mode2_active) begin
			core_buck_enable_m2 <= 1'b0;
			system_buck_enable_m2 <= 1'b0;
			always_on_reg_enable_m2 <= 1'b0;
			system_linear_reg_enable_m2 <= 1'b0;
			system_buck_code_m2 <= 5'h00;
			system_buck_offset_m2 <= 1'b0;
			system_buck_mv <= 12'h000;
			always_on_reg_code_m2 <= 4'h0;
			always_on_reg_mv <= 12'h000;
			watchdog_period_m2 <= WD_OFF;
			watchdog_period_s <= 8'h00;
			system_linear_reg_offset_m2 <= 1'b0;
		end else begin
			core_buck_enable_m2 <= rail_en_reg[CORE_BUCK_EN_POS];
			system_buck_enable_m2 <= rail_en_reg[SYS_BUCK_EN_POS];
			always_on_reg_enable_m2 <= rail_en_reg[AON_EN_POS];
			system_linear_reg_enable_m2 <= rail_en_reg[SYS_LIN_EN_POS];
			system_buck_code_m2 <= on_sysbuck_reg[SYS_BUCK_CODE_MSB:0];
			system_buck_offset_m2 <= on_sysbuck_reg[SYS_BUCK_OFFSET_POS];
			system_buck_mv <= sys_buck_mv_next;
			always_on_reg_code_m2 <= rail_en_reg[AON_CODE_MSB:AON_CODE_LSB];
			always_on_reg_mv <= aon_mv_next;
			watchdog_period_m2 <= watchdog_reg[WATCHDOG_MSB:WATCHDOG_LSB];
			watchdog_period_s <= wd_seconds(watchdog_reg[WATCHDOG_MSB:WATCHDOG_LSB]);
			system_linear_reg_offset_m2 <= watchdog_reg[SYS_LIN_OFFSET_POS];
		end
	end
endmodule

// *** m2pc_mode2_regs_properties.sv ***
// Port checker for the mode-2 configuration register bank.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module m2pc_mode2_regs_checker
	import m2pc_pkg::*;
(
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic scl_in, // SCL pin level.
	input wire logic sda_out, // SDA drive value.
	input wire logic sda_oe_n, // SDA enable, active low.
	input wire logic mode2_active, // Mode 2 active.
	input wire logic on_fall_valid, // ON-pin edge pulse.
	input wire logic return_to_mode0, // Mode 0 request.
	input wire logic core_buck_enable_m2, // Core buck enable.
	input wire logic [4:0] system_buck_code_m2, // Buck code.
	input wire logic system_buck_offset_m2, // Buck offset.
	input wire logic [11:0] system_buck_mv, // Buck millivolts.
	input wire logic [3:0] always_on_reg_code_m2, // Always-on code.
	input wire logic [11:0] always_on_reg_mv, // Always-on millivolts.
	input wire logic [1:0] watchdog_period_m2, // Watchdog select.
	input wire logic [7:0] watchdog_period_s // Watchdog seconds.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The reset cycle is excluded because the registered outputs are still zero there.
	ret_cause_a: assert property (return_to_mode0 |-> $past(on_fall_valid) && $past(mode2_active))
		else $error("mode 0 request without cause");
	ret_pulse_a: assert property (return_to_mode0 |=> !return_to_mode0)
		else $error("mode 0 request longer than one cycle");
	gated_off_a: assert property (!mode2_active |=> !core_buck_enable_m2 && system_buck_mv == 12'h000
		&& watchdog_period_m2 == WD_OFF && always_on_reg_code_m2 == 4'h0) else $error("outputs live outside mode 2");
	buck_mv_a: assert property ($past(mode2_active) && $past(rst_n) |-> system_buck_mv == SYS_BUCK_BASE_MV
		+ STEP_MV * (system_buck_code_m2 > SYS_BUCK_MAX_CODE ? SYS_BUCK_MAX_CODE : system_buck_code_m2)
		+ (system_buck_offset_m2 ? OFFSET_MV : 12'h000)) else $error("buck voltage wrong");
	aon_mv_a: assert property ($past(mode2_active) && $past(rst_n) |-> always_on_reg_mv == AON_BASE_MV
		+ STEP_MV * (always_on_reg_code_m2 > AON_MAX_CODE ? AON_MAX_CODE : always_on_reg_code_m2))
		else $error("always-on voltage wrong");
	wd_sec_a: assert property (watchdog_period_s == (watchdog_period_m2 == WD_OFF ? 8'h00
		: 8'h08 << watchdog_period_m2)) else $error("watchdog seconds wrong");
	reset_quiet_a: assert property ($rose(rst_n) |-> sda_oe_n && !return_to_mode0 && !core_buck_enable_m2)
		else $error("outputs active after reset");
	drive_low_a: assert property (!sda_oe_n |-> !sda_out)
		else $error("data line driven high");
	// The data line may only move while SCL is low, or the host would see a false start or stop.
	sda_scl_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data line moved while clock high");
endmodule
bind m2pc_mode2_regs m2pc_mode2_regs_checker chk_i (.clk, .rst_n, .scl_in, .sda_out, .sda_oe_n, .mode2_active,
	.on_fall_valid, .return_to_mode0, .core_buck_enable_m2, .system_buck_code_m2, .system_buck_offset_m2,
	.system_buck_mv, .always_on_reg_code_m2, .always_on_reg_mv, .watchdog_period_m2, .watchdog_period_s);

// *** m2pc_i2c_host.sv ***
// Bit-banged I2C host model for the register bank's target port.
// Assumes the bench resolves SDA with a pull-up, so a released line reads high.
`timescale 1ns/1ps
module m2pc_i2c_host #(
	parameter int QTR = 10 // Clocks per quarter bit.
) (
	input wire logic clk, // Bench clock.
	input wire logic sda_in, // Resolved SDA level.
	output logic scl, // SCL, never stretched by the target.
	output logic sda_o, // SDA drive, one releases.
	output logic res_valid, // One-cycle result strobe.
	output logic [7:0] res_data // Read byte or count of missing acks.
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
		res_valid = 1'b0;
		res_data = 8'h00;
	end
	task automatic wq();
		repeat (QTR) @(posedge clk);
	endtask
	task automatic put(input logic [7:0] d);
		res_data <= d;
		res_valid <= 1'b1;
		@(posedge clk);
		res_valid <= 1'b0;
	endtask
	// Data changes a quarter bit after SCL falls and is sampled mid-high.
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		wq();
		scl <= 1'b1;
		wq();
		r = sda_in;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] r, output logic n);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(ack, n);
	endtask
	task automatic start();
		sda_o <= 1'b1;
		wq();
		scl <= 1'b1;
		wq();
		sda_o <= 1'b0;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		wq();
		scl <= 1'b1;
		wq();
		sda_o <= 1'b1;
		wq();
	endtask
	task automatic write3(input logic [6:0] a, input logic [7:0] p, input logic [23:0] d);
		logic [39:0] w;
		logic [7:0] r;
		logic n;
		logic [7:0] miss;
		w = {a, 1'b0, p, d};
		miss = 8'h00;
		start();
		for (int i = 4; i >= 0 && miss == 8'h00; i--) begin
			byte_io(w[i*8 +: 8], 1'b1, r, n);
			miss = miss + {7'h00, n};
		end
		stop();
		put(miss);
	endtask
	task automatic read3(input logic [6:0] a, input logic [7:0] p);
		logic [7:0] r;
		logic n;
		start();
		byte_io({a, 1'b0}, 1'b1, r, n);
		byte_io(p, 1'b1, r, n);
		start();
		byte_io({a, 1'b1}, 1'b1, r, n);
		for (int i = 0; i < 3; i++) begin
			byte_io(8'hff, i == 2, r, n);
			put(r);
		end
		stop();
	endtask
endmodule

// *** m2pc_mode2_regs_bench.sv ***
// Self-checking bench for the mode-2 configuration register bank.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
module m2pc_mode2_regs_bench;
	import m2pc_pkg::*;
	localparam logic [6:0] ADDR = 7'h5A;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode2_active = 1'b0;
	logic on_fall_valid = 1'b0;
	logic scl, sda_o, sda_out, sda_oe_n, res_valid, return_to_mode0, core_buck_enable_m2, system_buck_enable_m2;
	logic always_on_reg_enable_m2, system_linear_reg_enable_m2, system_buck_offset_m2, system_linear_reg_offset_m2;
	logic [4:0] system_buck_code_m2;
	logic [3:0] always_on_reg_code_m2;
	logic [11:0] system_buck_mv, always_on_reg_mv;
	logic [1:0] watchdog_period_m2;
	logic [7:0] watchdog_period_s, res_data, b, c, d;
	logic [31:0] seed = 32'hd3fd;
	logic [7:0] expq[$];
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	wire sda = sda_o & (sda_oe_n | sda_out);
	always #2.5 clk = ~clk;
	m2pc_i2c_host host (.clk, .sda_in(sda), .scl, .sda_o, .res_valid, .res_data);
	m2pc_mode2_regs #(.I2C_TARGET_ADDR(ADDR)) dut (.clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
		.mode2_active, .on_fall_valid, .return_to_mode0, .core_buck_enable_m2, .system_buck_enable_m2,
		.always_on_reg_enable_m2, .system_linear_reg_enable_m2, .system_buck_code_m2, .system_buck_offset_m2,
		.system_buck_mv, .always_on_reg_code_m2, .always_on_reg_mv, .watchdog_period_m2, .watchdog_period_s,
		.system_linear_reg_offset_m2);
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [11:0] mv(input logic [11:0] base, input logic [7:0] lim, input logic [7:0] code);
		return base + STEP_MV * (code > lim ? lim : code);
	endfunction
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			stop_test();
		end
		if (res_valid === 1'b1) chk({4'h0, res_data}, {4'h0, expq.pop_front()});
	end
	task automatic rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		expq.push_back(e0);
		expq.push_back(e1);
		expq.push_back(e2);
		host.read3(ADDR, p);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [23:0] v, input logic [7:0] nacks);
		expq.push_back(nacks);
		host.write3(a, p, v);
	endtask
	task automatic outs(input logic on);
		logic [7:0] wds[4];
		wds = '{8'h00, WD_16S_SEC, WD_32S_SEC, WD_64S_SEC};
		// Look just after the edge, so the registered outputs have settled.
		repeat (3) @(posedge clk);
		#1;
		chk({system_buck_enable_m2, always_on_reg_enable_m2, system_linear_reg_enable_m2}, on ? c[2:0] : 3'h0);
		chk(core_buck_enable_m2, on & c[3]);
		chk(system_buck_code_m2, on ? b[4:0] : 5'h00);
		chk(system_buck_mv, on ? mv(SYS_BUCK_BASE_MV, SYS_BUCK_MAX_CODE, b[4:0]) + (b[5] ? OFFSET_MV : 12'h000) : 12'h000);
		chk(always_on_reg_code_m2, on ? c[7:4] : 4'h0);
		chk(always_on_reg_mv, on ? mv(AON_BASE_MV, AON_MAX_CODE, c[7:4]) : 12'h000);
		chk(watchdog_period_m2, on ? d[7:6] : 2'h0);
		chk(watchdog_period_s, on ? wds[d[7:6]] : 8'h00);
		chk({system_buck_offset_m2, system_linear_reg_offset_m2}, on ? {b[5], d[5]} : 2'h0);
		@(posedge clk);
	endtask
	task automatic onp(input logic exp);
		on_fall_valid <= 1'b1;
		@(posedge clk);
		on_fall_valid <= 1'b0;
		#1 chk(return_to_mode0, exp);
		@(posedge clk);
	endtask
	initial begin
		logic [4:0] bc[4];
		logic [3:0] ac[4];
		bc = '{5'h00, 5'h18, 5'h19, 5'h1f};
		ac = '{4'h0, 4'h8, 4'h9, 4'hf};
		b = REG_ON_SYSBUCK_RESET;
		c = REG_RAIL_EN_RESET;
		d = REG_WATCHDOG_RESET;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		outs(1'b0);
		mode2_active <= 1'b1;
		outs(1'b1);
		rd(8'h2b, 8'h4c, 8'h4f, 8'h0c);
		onp(1'b0);
		$display("reset test done");
		// Clamp boundaries and the watchdog field are chosen by hand; the other bits come from the random source.
		for (int i = 0; i < 4; i++) begin
			b = (rnd() & 8'he0) | {3'h0, bc[i]};
			c = {ac[i], 4'(rnd())};
			d = {i[1:0], 6'(rnd())};
			wr(ADDR, 8'h2b, {b, c, d}, 8'h00);
			rd(8'h2b, b, c, d);
			outs(1'b1);
		end
		rd(8'h2c, c, d, 8'h00);
		$display("field test done");
		b = b & 8'hbf;
		wr(ADDR, 8'h2b, {b, c, d}, 8'h00);
		onp(1'b1);
		mode2_active <= 1'b0;
		onp(1'b0);
		outs(1'b0);
		rd(8'h2b, b, c, d);
		wr(ADDR ^ 7'h01, 8'h2b, 24'h0000_00, 8'h01);
		rd(8'h2b, b, c, d);
		$display("mode test done");
		repeat (8) @(posedge clk);
		stop_test();
	end
endmodule
